// ===== sstc_pkg.sv
// Package for the sink sync timing control block: offsets, reset values, state.
// Assumes one clock for the register port and the timing generator.
package sstc_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] SSTC_OFF_CAUSE  = 12'h048;
	localparam logic [11:0] SSTC_OFF_HSYNC  = 12'h050;
	localparam logic [11:0] SSTC_OFF_VSYNC  = 12'h058;
	localparam logic [11:0] SSTC_OFF_I2CDIV = 12'h060;
	localparam logic [11:0] SSTC_OFF_TP1    = 12'h064;

	// ==========================================================
	// Reset values and field positions
	localparam logic [15:0] SSTC_RST_HSYNC  = 16'h0F0F;
	localparam logic [15:0] SSTC_RST_VSYNC  = 16'h003F;
	localparam logic [7:0]  SSTC_RST_I2CDIV = 8'h00;
	localparam logic [31:0] SSTC_RST_TP1    = 32'h0000_0000;
	localparam logic [7:0]  SSTC_I2CDIV_DEF = 8'h00;
	localparam int          SSTC_TP1_EN_BIT = 31;
	localparam int          SSTC_EVT_W      = 6;
	localparam int          SSTC_S3_LSB     = 6;

	// ==========================================================
	// AXI4-Lite responses
	localparam logic [1:0] SSTC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SSTC_RESP_SLVERR = 2'h2;

	// ==========================================================
	// State
	typedef enum logic [1:0] {
		SSTC_TG_IDLE,
		SSTC_TG_PORCH,
		SSTC_TG_PULSE
	} sstc_tg_state_t;

	typedef struct packed {
		logic [15:0]    hsync_timing;
		logic [15:0]    vsync_timing;
		logic [7:0]     fast_i2c_clock_divider;
		logic [31:0]    tp1_score_override;
		logic [11:0]    cause;
		sstc_tg_state_t tg_state;
		logic [7:0]     h_cnt;
		logic           hsync;
		logic [15:0]    v_cnt;
		logic           vsync;
		logic [7:0]     i2c_div;
		logic [14:0]    tp1_score;
		logic           awready;
		logic           wready;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           arready;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
	} sstc_state_t;

endpackage

// ===== sstc_top.sv
// Sync timing control: sync generator, sync widths, fast I2C divider, score override,
// secondary event causes for streams 2 and 3, all behind an AXI4-Lite slave.
// Assumes line/frame markers and event pulses come from logic on I_CLK.
//
// Summary of operation
// - Cause bits 0-5 are stream 2 events; stream 3 same order from bit 6.
// - Reading or writing the cause register clears it; reserved bits read zero.
// - Porch count from bits 15:8 delays hsync after the last active pixel.
// - Hsync is high for bits 7:0 cycles; register resets to 0x0F0F.
// - Vsync is high for the 16-bit width count; resets to 0x003F.
// - Fast I2C divider applies only with DPCD revision 1.2.
// - Override register holds a 15-bit replacement score in bits 14:0.
// - Bit 31 set selects the programmed score, clear selects the computed one.
`timescale 1ns/10ps

module sstc_top (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	input  wire logic [11:0] I_AXI_AWADDR,
	input  wire logic        I_AXI_AWVALID,
	output logic             O_AXI_AWREADY,
	input  wire logic [31:0] I_AXI_WDATA,
	input  wire logic [3:0]  I_AXI_WSTRB,
	input  wire logic        I_AXI_WVALID,
	output logic             O_AXI_WREADY,
	output logic [1:0]       O_AXI_BRESP,
	output logic             O_AXI_BVALID,
	input  wire logic        I_AXI_BREADY,
	input  wire logic [11:0] I_AXI_ARADDR,
	input  wire logic        I_AXI_ARVALID,
	output logic             O_AXI_ARREADY,
	output logic [31:0]      O_AXI_RDATA,
	output logic [1:0]       O_AXI_RRESP,
	output logic             O_AXI_RVALID,
	input  wire logic        I_AXI_RREADY,
	input  wire logic        I_LINE_END,
	input  wire logic        I_FRAME_END,
	input  wire logic [5:0]  I_STRM2_EVT,
	input  wire logic [5:0]  I_STRM3_EVT,
	input  wire logic        I_DPCD_REV12,
	input  wire logic [14:0] I_TP1_SCORE,
	output logic             O_HSYNC,
	output logic             O_VSYNC,
	output logic [7:0]       O_I2C_DIV,
	output logic [14:0]      O_TP1_SCORE
);
	import sstc_pkg::*;

	sstc_state_t st_reg;
	sstc_state_t st_next;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] strb);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic        wr_go;
	logic        rd_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_val;
	logic [31:0] wr_word;
	logic [11:0] evt_in;

	// ==========================================================
	// Bus decode
	always_comb begin
		wr_go = I_AXI_AWVALID && I_AXI_WVALID && !st_reg.awready && !st_reg.bvalid;
		rd_go = I_AXI_ARVALID && !st_reg.arready && !st_reg.rvalid;
		evt_in = {I_STRM3_EVT, I_STRM2_EVT};
		wr_hit = 1'b1;
		wr_word = 32'h0000_0000;
		case (I_AXI_AWADDR)
			SSTC_OFF_HSYNC:  wr_word = {16'h0000, st_reg.hsync_timing};
			SSTC_OFF_VSYNC:  wr_word = {16'h0000, st_reg.vsync_timing};
			SSTC_OFF_I2CDIV: wr_word = {24'h000000, st_reg.fast_i2c_clock_divider};
			SSTC_OFF_TP1:    wr_word = st_reg.tp1_score_override;
			SSTC_OFF_CAUSE:  wr_word = 32'h0000_0000;
			default:         wr_hit = 1'b0;
		endcase
		wr_word = merge_bytes(wr_word, I_AXI_WDATA, I_AXI_WSTRB);
		rd_hit = 1'b1;
		case (I_AXI_ARADDR)
			SSTC_OFF_HSYNC:  rd_val = {16'h0000, st_reg.hsync_timing};
			SSTC_OFF_VSYNC:  rd_val = {16'h0000, st_reg.vsync_timing};
			SSTC_OFF_I2CDIV: rd_val = {24'h000000, st_reg.fast_i2c_clock_divider};
			SSTC_OFF_TP1:    rd_val = st_reg.tp1_score_override;
			SSTC_OFF_CAUSE:  rd_val = {20'h00000, st_reg.cause};
			default: begin
				rd_val = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;

		// Write channel: address and data taken together, one cycle ready pulse
		st_next.awready = wr_go;
		st_next.wready  = wr_go;
		if (st_reg.bvalid && I_AXI_BREADY) begin
			st_next.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_next.bvalid = 1'b1;
			st_next.bresp  = wr_hit ? SSTC_RESP_OKAY : SSTC_RESP_SLVERR;
			case (I_AXI_AWADDR)
				SSTC_OFF_HSYNC:  st_next.hsync_timing = wr_word[15:0];
				SSTC_OFF_VSYNC:  st_next.vsync_timing = wr_word[15:0];
				SSTC_OFF_I2CDIV: st_next.fast_i2c_clock_divider = wr_word[7:0];
				SSTC_OFF_TP1:    st_next.tp1_score_override = wr_word;
				default:         st_next.hsync_timing = st_reg.hsync_timing;
			endcase
		end

		// Read channel: data captured at the address handshake
		st_next.arready = rd_go;
		if (st_reg.rvalid && I_AXI_RREADY) begin
			st_next.rvalid = 1'b0;
		end
		if (rd_go) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_val;
			st_next.rresp  = rd_hit ? SSTC_RESP_OKAY : SSTC_RESP_SLVERR;
		end

		// Event causes: a new event wins over the clear in the same cycle
		if ((rd_go && I_AXI_ARADDR == SSTC_OFF_CAUSE)
			|| (wr_go && I_AXI_AWADDR == SSTC_OFF_CAUSE)) begin
			st_next.cause = evt_in;
		end else begin
			st_next.cause = st_reg.cause | evt_in;
		end

		// Horizontal sync generator; a new line end restarts the sequence
		if (I_LINE_END) begin
			if (st_reg.hsync_timing[15:8] != 8'h00) begin
				st_next.tg_state = SSTC_TG_PORCH;
				st_next.h_cnt    = st_reg.hsync_timing[15:8];
				st_next.hsync    = 1'b0;
			end else if (st_reg.hsync_timing[7:0] != 8'h00) begin
				st_next.tg_state = SSTC_TG_PULSE;
				st_next.h_cnt    = st_reg.hsync_timing[7:0];
				st_next.hsync    = 1'b1;
			end else begin
				st_next.tg_state = SSTC_TG_IDLE;
				st_next.hsync    = 1'b0;
			end
		end else begin
			case (st_reg.tg_state)
				SSTC_TG_IDLE: begin
					st_next.hsync = 1'b0;
				end
				SSTC_TG_PORCH: begin
					if (st_reg.h_cnt == 8'h01) begin
						if (st_reg.hsync_timing[7:0] != 8'h00) begin
							st_next.tg_state = SSTC_TG_PULSE;
							st_next.h_cnt    = st_reg.hsync_timing[7:0];
							st_next.hsync    = 1'b1;
						end else begin
							st_next.tg_state = SSTC_TG_IDLE;
						end
					end else begin
						st_next.h_cnt = st_reg.h_cnt - 8'h01;
					end
				end
				SSTC_TG_PULSE: begin
					if (st_reg.h_cnt == 8'h01) begin
						st_next.tg_state = SSTC_TG_IDLE;
						st_next.hsync    = 1'b0;
					end else begin
						st_next.h_cnt = st_reg.h_cnt - 8'h01;
					end
				end
				default: begin
					st_next.tg_state = SSTC_TG_IDLE;
					st_next.hsync    = 1'b0;
				end
			endcase
		end

		// Vertical sync: width sampled at the frame marker
		if (I_FRAME_END && st_reg.vsync_timing != 16'h0000) begin
			st_next.v_cnt = st_reg.vsync_timing;
			st_next.vsync = 1'b1;
		end else if (st_reg.v_cnt > 16'h0001) begin
			st_next.v_cnt = st_reg.v_cnt - 16'h0001;
		end else begin
			st_next.v_cnt = 16'h0000;
			st_next.vsync = 1'b0;
		end

		// Divider only meaningful for the newer DPCD revision
		st_next.i2c_div = I_DPCD_REV12 ? st_reg.fast_i2c_clock_divider
			: SSTC_I2CDIV_DEF;

		st_next.tp1_score = st_reg.tp1_score_override[SSTC_TP1_EN_BIT]
			? st_reg.tp1_score_override[14:0] : I_TP1_SCORE;
	end

	// ==========================================================
	// State register
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			st_reg                        <= '0;
			st_reg.hsync_timing           <= SSTC_RST_HSYNC;
			st_reg.vsync_timing           <= SSTC_RST_VSYNC;
			st_reg.fast_i2c_clock_divider <= SSTC_RST_I2CDIV;
			st_reg.tp1_score_override     <= SSTC_RST_TP1;
			st_reg.tg_state               <= SSTC_TG_IDLE;
			st_reg.i2c_div                <= SSTC_I2CDIV_DEF;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_AXI_AWREADY = st_reg.awready;
	assign O_AXI_WREADY  = st_reg.wready;
	assign O_AXI_BRESP   = st_reg.bresp;
	assign O_AXI_BVALID  = st_reg.bvalid;
	assign O_AXI_ARREADY = st_reg.arready;
	assign O_AXI_RDATA   = st_reg.rdata;
	assign O_AXI_RRESP   = st_reg.rresp;
	assign O_AXI_RVALID  = st_reg.rvalid;
	assign O_HSYNC       = st_reg.hsync;
	assign O_VSYNC       = st_reg.vsync;
	assign O_I2C_DIV     = st_reg.i2c_div;
	assign O_TP1_SCORE   = st_reg.tp1_score;

endmodule // sstc_top

// ===== sstc_top_asserts.sv
// Checker for sstc_top: sync shapes, bus answers, output gating.
// Assumes full-strobe register writes.
`timescale 1ns/10ps
module sstc_top_asserts (
	input wire logic        I_CLK,
	input wire logic        I_RST_B,
	input wire logic [11:0] I_AXI_AWADDR,
	input wire logic        I_AXI_AWVALID,
	input wire logic        O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic        I_AXI_WVALID,
	input wire logic        O_AXI_WREADY,
	input wire logic [1:0]  O_AXI_BRESP,
	input wire logic        O_AXI_BVALID,
	input wire logic        I_AXI_BREADY,
	input wire logic [11:0] I_AXI_ARADDR,
	input wire logic        I_AXI_ARVALID,
	input wire logic        O_AXI_ARREADY,
	input wire logic [31:0] O_AXI_RDATA,
	input wire logic [1:0]  O_AXI_RRESP,
	input wire logic        O_AXI_RVALID,
	input wire logic        I_LINE_END,
	input wire logic        I_FRAME_END,
	input wire logic [5:0]  I_STRM2_EVT,
	input wire logic        I_DPCD_REV12,
	input wire logic [14:0] I_TP1_SCORE,
	input wire logic        O_HSYNC,
	input wire logic        O_VSYNC,
	input wire logic [7:0]  O_I2C_DIV,
	input wire logic [14:0] O_TP1_SCORE
);
	import sstc_pkg::*;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	// ====
	// Shadow registers, one edge behind the design
	logic [15:0] h_reg, v_reg;
	logic [16:0] hc, vc;
	logic [15:0] tp_reg;
	logic        wr_go;
	assign wr_go = O_AXI_AWREADY;
	always_ff @(posedge I_CLK) begin
		if (!I_RST_B) begin
			h_reg <= SSTC_RST_HSYNC;
			v_reg <= SSTC_RST_VSYNC;
			tp_reg <= 16'h0000;
			hc <= 17'h1FFFF;
			vc <= 17'h1FFFF;
		end else begin
			if (wr_go && I_AXI_AWADDR == SSTC_OFF_HSYNC) h_reg <= I_AXI_WDATA[15:0];
			if (wr_go && I_AXI_AWADDR == SSTC_OFF_VSYNC) v_reg <= I_AXI_WDATA[15:0];
			if (wr_go && I_AXI_AWADDR == SSTC_OFF_TP1) tp_reg <= {I_AXI_WDATA[31], I_AXI_WDATA[14:0]};
			// Saturating, so an idle line never looks like a pulse
			hc <= I_LINE_END ? 17'h1 : (hc == 17'h1FFFF ? hc : hc + 17'h1);
			vc <= I_FRAME_END ? 17'h1 : (vc == 17'h1FFFF ? vc : vc + 17'h1);
		end
	end
	// ====
	// Sequences
	sequence s_rd_take;
		I_AXI_ARVALID && !O_AXI_ARREADY && !O_AXI_RVALID;
	endsequence
	sequence s_evt_rd;
		(I_STRM2_EVT != 6'h00) ##1 (s_rd_take and (I_AXI_ARADDR == SSTC_OFF_CAUSE));
	endsequence
	// ====
	// Properties
	chk_hsync_shape: assert property (O_HSYNC == (
		hc >= {9'h000, h_reg[15:8]} + 17'h1 &&
		hc <= {9'h000, h_reg[15:8]} + {9'h000, h_reg[7:0]})) else $error("hsync shape wrong");
	chk_vsync_shape: assert property (O_VSYNC == (vc >= 17'h1 && vc <= {1'b0, v_reg}))
		else $error("vsync shape wrong");
	chk_i2c_gated: assert property (!I_DPCD_REV12 |=> O_I2C_DIV == 8'h00)
		else $error("divider not gated");
	chk_tp1_own: assert property (!tp_reg[15] && !wr_go |=> O_TP1_SCORE == $past(I_TP1_SCORE))
		else $error("computed score not used");
	chk_tp1_override: assert property (tp_reg[15] && !wr_go |=> O_TP1_SCORE == tp_reg[14:0])
		else $error("override score not used");
	chk_write_answer: assert property (I_AXI_AWVALID && I_AXI_WVALID && !O_AXI_AWREADY
		&& !O_AXI_BVALID |=> O_AXI_AWREADY && O_AXI_WREADY && O_AXI_BVALID)
		else $error("write not answered");
	chk_bresp_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY
		|=> O_AXI_BVALID && $stable(O_AXI_BRESP)) else $error("write response dropped");
	chk_read_answer: assert property (s_rd_take |=> O_AXI_ARREADY && O_AXI_RVALID)
		else $error("read not answered");
	chk_cause_map: assert property (s_evt_rd |=> (O_AXI_RDATA[5:0] & $past(I_STRM2_EVT, 2))
		== $past(I_STRM2_EVT, 2) && O_AXI_RDATA[31:12] == 20'h0) else $error("cause bits wrong");
endmodule // sstc_top_asserts

bind sstc_top sstc_top_asserts u_chk (.*);

// ===== sstc_video_sink.sv
// Downstream video logic model: measures sync pulse lengths.
// Assumes sync levels change on the rising clock edge.
`timescale 1ns/10ps
module sstc_video_sink (
	input  wire logic        i_clk,
	input  wire logic        i_hsync,
	input  wire logic        i_vsync,
	output logic      [15:0] o_h_width,
	output logic      [15:0] o_v_width
);
	logic [15:0] hc = 16'h0000;
	logic [15:0] vc = 16'h0000;
	initial begin
		o_h_width = 16'h0000;
		o_v_width = 16'h0000;
	end
	always @(posedge i_clk) begin
		hc <= i_hsync ? hc + 16'h1 : 16'h0;
		vc <= i_vsync ? vc + 16'h1 : 16'h0;
		if (!i_hsync && hc != 16'h0) o_h_width <= hc;
		if (!i_vsync && vc != 16'h0) o_v_width <= vc;
	end
endmodule // sstc_video_sink

// ===== test_sink_sync_timing_control.sv
// Testbench for sstc_top with a sync-measuring sink.
// Assumes the checker is bound in by its own file.
`timescale 1ns/10ps
module test_sink_sync_timing_control;
	import sstc_pkg::*;
	logic clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, le = 0, fe = 0, rev = 0;
	logic [11:0] aa = 0, ra = 0;
	logic [31:0] wd = 0, rdat, d, v;
	logic [5:0] e2 = 0, e3 = 0;
	logic [14:0] ts = 0, tsc;
	logic awr, wr, bv, arr, rv, hs, vs;
	logic [1:0] br, rr, r;
	logic [7:0] idiv;
	logic [15:0] hw, vw, lf = 16'h0030;
	int err_count = 0, n_compared = 0, i, k;
	always #50 clk = ~clk;
	sstc_top dut (.I_CLK(clk), .I_RST_B(rst_b), .I_AXI_AWADDR(aa), .I_AXI_AWVALID(awv),
		.O_AXI_AWREADY(awr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wv),
		.O_AXI_WREADY(wr), .O_AXI_BRESP(br), .O_AXI_BVALID(bv), .I_AXI_BREADY(bry),
		.I_AXI_ARADDR(ra), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .O_AXI_RDATA(rdat),
		.O_AXI_RRESP(rr), .O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .I_LINE_END(le),
		.I_FRAME_END(fe), .I_STRM2_EVT(e2), .I_STRM3_EVT(e3), .I_DPCD_REV12(rev),
		.I_TP1_SCORE(ts), .O_HSYNC(hs), .O_VSYNC(vs), .O_I2C_DIV(idiv), .O_TP1_SCORE(tsc));
	sstc_video_sink u_sink (.i_clk(clk), .i_hsync(hs), .i_vsync(vs), .o_h_width(hw), .o_v_width(vw));
	// ====
	// Helpers
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [31:0] rb(input logic [11:0] a, input logic [31:0] x);
		return a == SSTC_OFF_TP1 ? x : (a == SSTC_OFF_I2CDIV ? {24'h0, x[7:0]} : {16'h0, x[15:0]});
	endfunction
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	// Response held with ready low first, so the hold is exercised
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] x, output logic [1:0] q);
		int n = 0;
		aa = a;
		wd = x;
		awv = 1;
		wv = 1;
		do @(negedge clk); while (!awr && ++n < 20);
		if (n >= 20) err_count++;
		@(negedge clk);
		awv = 0;
		wv = 0;
		@(negedge clk);
		q = br;
		bry = 1;
		@(negedge clk);
		bry = 0;
	endtask
	task automatic rd_reg(input logic [11:0] a, output logic [31:0] x, output logic [1:0] q);
		int n = 0;
		ra = a;
		arv = 1;
		do @(negedge clk); while (!arr && ++n < 20);
		if (n >= 20) err_count++;
		@(negedge clk);
		arv = 0;
		x = rdat;
		q = rr;
		rry = 1;
		@(negedge clk);
		rry = 0;
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ====
	// Scenarios
	initial begin
		#(20000 * 100);
		err_count++;
		final_report;
	end
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1;
		rd_reg(SSTC_OFF_HSYNC, d, r); cmp("hsync reset", 32'h0F0F, d);
		rd_reg(SSTC_OFF_VSYNC, d, r); cmp("vsync reset", 32'h003F, d);
		rd_reg(12'h100, d, r); cmp("unmapped data", 32'h0, d);
		cmp("unmapped rresp", 32'h2, {30'h0, r});
		wr_reg(12'h100, 32'h1, r); cmp("unmapped resp", 32'h2, {30'h0, r});
		for (i = 0; i < 12; i++) begin
			lf = nx(lf);
			aa = i % 3 == 0 ? SSTC_OFF_HSYNC : (i % 3 == 1 ? SSTC_OFF_I2CDIV : SSTC_OFF_TP1);
			v = {lf, nx(lf)};
			ra = aa;
			wr_reg(ra, v, r);
			rd_reg(ra, d, r); cmp("readback", rb(ra, v), d);
			cmp("readback resp", 32'h0, {30'h0, r});
		end
		// Porch of zero is the corner case
		for (i = 0; i < 3; i++) begin
			lf = nx(lf);
			// Width kept 8 bits wide so a nibble of all ones cannot wrap to zero
			v = {16'h0, (i == 0) ? 8'h00 : {4'h0, lf[3:0]}, 8'({4'h0, lf[7:4]} + 8'h01)};
			wr_reg(SSTC_OFF_HSYNC, v, r);
			le = 1;
			@(negedge clk);
			le = 0;
			repeat (40) @(negedge clk);
			cmp("hsync width", {24'h0, v[7:0]}, {16'h0, hw});
		end
		v = 32'h0040 + lf[3:0];
		wr_reg(SSTC_OFF_VSYNC, v, r);
		fe = 1;
		@(negedge clk);
		fe = 0;
		repeat (90) @(negedge clk);
		cmp("vsync width", v, {16'h0, vw});
		wr_reg(SSTC_OFF_I2CDIV, 32'h5A, r);
		rev = 1;
		repeat (2) @(negedge clk);
		cmp("divider on", 32'h5A, {24'h0, idiv});
		rev = 0;
		repeat (2) @(negedge clk);
		cmp("divider off", 32'h0, {24'h0, idiv});
		ts = lf[14:0];
		wr_reg(SSTC_OFF_TP1, 32'h8000_1234, r);
		repeat (2) @(negedge clk);
		cmp("score override", 32'h1234, {17'h0, tsc});
		wr_reg(SSTC_OFF_TP1, 32'h0000_1234, r);
		repeat (2) @(negedge clk);
		cmp("score own", {17'h0, ts}, {17'h0, tsc});
		for (k = 0; k < 6; k++) begin
			e2 = 6'h1 << k;
			e3 = 6'h1 << k;
			@(negedge clk);
			e2 = 0;
			e3 = 0;
			rd_reg(SSTC_OFF_CAUSE, d, r); cmp("cause", (32'h1 << k) | (32'h40 << k), d);
			rd_reg(SSTC_OFF_CAUSE, d, r); cmp("cause cleared", 32'h0, d);
		end
		e2 = 6'h3F;
		@(negedge clk);
		e2 = 0;
		wr_reg(SSTC_OFF_CAUSE, 32'hFFFF_FFFF, r);
		cmp("cause write resp", 32'h0, {30'h0, r});
		rd_reg(SSTC_OFF_CAUSE, d, r); cmp("cause write", 32'h0, d);
		final_report;
	end
endmodule // test_sink_sync_timing_control
